// ### design/bist_params.svh
`ifndef BIST_PARAMS_SVH
`define BIST_PARAMS_SVH
// Register index as printed, byte address is four times it
`define STC_INDEX   8'h16
`define STC_ADDR    (`STC_INDEX << 2)
// Fixed read value of bits 8:7
`define RSV_MID     2'h2
// Control register reset value
`define CTL_RESET   16'h0000
// Loopback select codes
`define LB_NONE     4'h0
`define LB_PCS      4'h1
`define LB_ANALOG   4'h2
`define LB_REVERSE  4'h4
`define LB_RSVD     4'h8
// Payload bit of constant-data packets
`define CONST_BIT   1'h1
// PRBS generator seed, any non-zero value
`define PRBS_SEED   15'h7fff
`endif

// ### design/bist_pkg.sv
package bist_pkg;

	// Self-test control word, bit 15 down to bit 0
	typedef struct packed {
		logic       rsv_top;   // Bit 15, reads zero
		logic       err_mode;  // 1 = continuous error count
		logic       pkt_type;  // 1 = PRBS packets
		logic       gen_en;    // Generator enable
		logic       lock;      // Checker locked
		logic       loss;      // Sync lost, latched
		logic       gen_stat;  // Generator active
		logic [1:0] rsv_mid;   // Fixed pattern
		logic       mdi_fwd;   // Forward to MDI in xMII loopback
		logic [3:0] lb_sel;    // Loopback select
		logic [1:0] rsv_lo;    // Plain storage
	} ctl_s;

	// Generator states, Gray along idle-send-gap
	typedef enum logic [1:0] {
		G_IDLE = 2'b00,
		G_SEND = 2'b01,
		G_GAP  = 2'b11,
		G_DONE = 2'b10
	} gen_state_e;

	typedef logic [14:0] prbs_t;

	// Next bit of x^15 + x^14 + 1
	function automatic logic prbs_fb(input prbs_t s);
		prbs_fb = s[14] ^ s[13];
	endfunction : prbs_fb

endpackage : bist_pkg

// ### design/prbs_source.sv
`timescale 1ns/100ps
`default_nettype none
`include "bist_params.svh"
// PRBS15 generator, steps once per advance
module prbs_source (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic advance,
	output var  logic bit_out
);
	import bist_pkg::*;

	prbs_t sh_reg; // Shift state, never all zero

	////////////////////////////////////////////////////////////////////
	// Shift register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sh_reg <= `PRBS_SEED;
		end else if (advance) begin
			sh_reg <= {sh_reg[13:0], prbs_fb(sh_reg)};
		end
	end

	// Next bit is the feedback of the current state
	assign bit_out = prbs_fb(sh_reg);

endmodule : prbs_source
`default_nettype wire

// ### design/bist_err_counter.sv
`timescale 1ns/100ps
`default_nettype none
// Checker error counter, saturating or wrapping
module bist_err_counter #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic             inc,
	input  wire logic             cont_mode,
	output var  logic [WIDTH-1:0] count_reg,
	output var  logic             wrap_reg
);
	localparam logic [WIDTH-1:0] MAXV = '1; // Top of count

	////////////////////////////////////////////////////////////////////
	// Count and wrap pulse
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			count_reg <= '0;
			wrap_reg  <= 1'b0;
		end else begin
			wrap_reg <= 1'b0;
			if (inc && count_reg == MAXV) begin
				// Single mode simply holds at the top
				if (cont_mode) begin
					count_reg <= '0; // R01
					wrap_reg  <= 1'b1; // R01
				end
			end else if (inc) begin
				count_reg <= count_reg + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_wrap;
		inc && cont_mode && count_reg == MAXV |=>
			wrap_reg && count_reg == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap at max"); // R01

	property p_sat;
		inc && !cont_mode && count_reg == MAXV |=>
			!wrap_reg && count_reg == MAXV;
	endproperty
	a_sat: assert property (p_sat) else $error("count left max"); // R02

endmodule : bist_err_counter
`default_nettype wire

// ### design/prbs_bist_loopback_ctrl.sv
// Summary of operation
// R01 - Continuous mode: pulse at max, restart zero
// R02 - Single mode: stop counting at max
// R03 - PRBS type plus enable: endless PRBS packets
// R04 - PRBS type, generator off: checker stays on
// R05 - Constant type: one packet, no PRBS
// R06 - Enable bit starts, clearing stops generator
// R07 - Lock bit shows checker synchronised
// R08 - Sync loss latches until read
// R09 - Status bit shows generator active
// R10 - Codes 1,2,4 pick PCS, analog, reverse
// R11 - Code 0 normal, code 8 reserved
// R12 - Bit 6 forwards xMII loopback data to MDI
// R13 - Software sets bit 6 only in xMII loopback
// R14 - Checker compares local PRBS, counts mismatches
`timescale 1ns/100ps
`default_nettype none
`include "bist_params.svh"
module prbs_bist_loopback_ctrl #(
	parameter int PKT_BITS     = 256,
	parameter int GAP_BITS     = 16,
	parameter int LOCK_MATCHES = 32,
	parameter int LOSS_MISSES  = 4,
	parameter int ERR_WIDTH    = 16
) (
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	input  wire logic [7:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output var  logic [31:0]          avs_readdata,
	output var  logic                 avs_waitrequest,
	input  wire logic                 xmii_loopback,
	input  wire logic                 rx_bit,
	input  wire logic                 rx_valid,
	output var  logic                 tx_bit,
	output var  logic                 tx_valid,
	output var  logic                 lb_pcs,
	output var  logic                 lb_analog,
	output var  logic                 lb_reverse,
	output var  logic                 mdi_tx_en,
	output var  logic [ERR_WIDTH-1:0] err_count,
	output var  logic                 err_wrap
);
	import bist_pkg::*;

	localparam logic [15:0] PKT_LAST  = 16'(PKT_BITS - 1);
	localparam logic [15:0] GAP_LAST  = 16'(GAP_BITS - 1);
	localparam logic [7:0]  LOCK_LAST = 8'(LOCK_MATCHES - 1);
	localparam logic [7:0]  LOSS_LAST = 8'(LOSS_MISSES - 1);

	ctl_s       ctl_reg;        // Software-written fields
	ctl_s       wv;             // Write data as fields
	ctl_s       rv;             // Read view
	logic       wait_reg;       // Waitrequest flop
	logic [31:0] rdata_reg;     // Read data flop
	logic       hit;            // Address matches the register
	logic       wr_done;        // Write completes this edge
	logic       rd_take;        // Read taken this edge
	gen_state_e st_reg;         // Generator state
	logic [15:0] bit_cnt_reg;   // Bits in packet or gap
	logic       gen_active_reg; // Generator status
	logic       prbs_bit;       // Next PRBS bit to send
	logic       tx_bit_reg;
	logic       tx_valid_reg;
	logic       lb_pcs_reg;
	logic       lb_analog_reg;
	logic       lb_reverse_reg;
	logic       mdi_tx_en_reg;
	prbs_t      chk_sh_reg;     // Checker local sequence
	logic       chk_pred;       // Predicted received bit
	logic       lock_reg;       // Checker locked
	logic       loss_reg;       // Sync lost, latched
	logic [7:0] match_cnt_reg;  // Matches while hunting
	logic [7:0] miss_cnt_reg;   // Back-to-back misses when locked
	logic       chk_en;         // Checker running
	logic       mismatch;       // Received bit differs
	logic       err_inc;        // One bit error

	////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait state, then the transfer completes
	assign hit     = avs_address == `STC_ADDR;
	assign wr_done = avs_write && !wait_reg;
	assign rd_take = avs_read && wait_reg;
	assign wv      = ctl_s'(avs_writedata[15:0]);

	// Waitrequest drops for exactly one edge per request
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wait_reg <= 1'b1;
		end else begin
			wait_reg <= !((avs_read || avs_write) && wait_reg);
		end
	end

	// Read view with live status; fixed bits forced
	always_comb begin
		rv          = ctl_reg;
		rv.rsv_top  = 1'b0;
		rv.lock     = lock_reg; // R07
		rv.loss     = loss_reg; // R08
		rv.gen_stat = gen_active_reg; // R09
		rv.rsv_mid  = `RSV_MID;
	end

	// Read data captured while waitrequest is high
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdata_reg <= 32'h0000_0000;
		end else if (rd_take) begin
			// Unmapped addresses read zero
			rdata_reg <= hit ? {16'h0000, rv} : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control fields, byte lanes honoured; status bits not writable
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctl_reg <= ctl_s'(`CTL_RESET);
		end else if (wr_done && hit) begin
			if (avs_byteenable[1]) begin
				ctl_reg.err_mode <= wv.err_mode;
				ctl_reg.pkt_type <= wv.pkt_type;
				ctl_reg.gen_en   <= wv.gen_en; // R06
			end
			if (avs_byteenable[0]) begin
				ctl_reg.mdi_fwd <= wv.mdi_fwd;
				ctl_reg.lb_sel  <= wv.lb_sel;
				ctl_reg.rsv_lo  <= wv.rsv_lo;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Packet generator
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_reg      <= G_IDLE;
			bit_cnt_reg <= 16'h0000;
		end else if (!ctl_reg.gen_en) begin
			// Clearing the enable stops at once
			st_reg      <= G_IDLE; // R06
			bit_cnt_reg <= 16'h0000;
		end else begin
			case (st_reg)
			G_IDLE: begin
				st_reg      <= G_SEND; // R06
				bit_cnt_reg <= 16'h0000;
			end
			G_SEND: begin
				if (bit_cnt_reg == PKT_LAST) begin
					bit_cnt_reg <= 16'h0000;
					// PRBS repeats, constant sends once
					st_reg <= ctl_reg.pkt_type ? G_GAP : G_DONE; // R03 R05
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 16'h0001;
				end
			end
			G_GAP: begin
				if (bit_cnt_reg == GAP_LAST) begin
					bit_cnt_reg <= 16'h0000;
					st_reg      <= G_SEND; // R03
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 16'h0001;
				end
			end
			G_DONE: begin
				// New constant packet needs enable cleared first
				st_reg <= G_DONE; // R05
			end
			default: begin
				st_reg <= G_IDLE;
			end
			endcase
		end
	end

	// PRBS advances only for PRBS payload bits
	prbs_source u_prbs (
		.clk_sys (clk_sys),
		.reset   (reset),
		.advance (st_reg == G_SEND && ctl_reg.pkt_type), // R05
		.bit_out (prbs_bit)
	);

	// Serial output and status
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tx_bit_reg     <= 1'b0;
			tx_valid_reg   <= 1'b0;
			gen_active_reg <= 1'b0;
		end else begin
			tx_valid_reg   <= st_reg == G_SEND;
			gen_active_reg <= st_reg == G_SEND || st_reg == G_GAP; // R09
			if (st_reg != G_SEND) begin
				tx_bit_reg <= 1'b0;
			end else if (ctl_reg.pkt_type) begin
				tx_bit_reg <= prbs_bit; // R03
			end else begin
				tx_bit_reg <= `CONST_BIT; // R05
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Loopback path select and MDI forwarding
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			lb_pcs_reg     <= 1'b0;
			lb_analog_reg  <= 1'b0;
			lb_reverse_reg <= 1'b0;
			mdi_tx_en_reg  <= 1'b1;
		end else begin
			// Code 0, code 8 and mixed codes leave every path off
			lb_pcs_reg     <= ctl_reg.lb_sel == `LB_PCS; // R10 R11
			lb_analog_reg  <= ctl_reg.lb_sel == `LB_ANALOG; // R10
			lb_reverse_reg <= ctl_reg.lb_sel == `LB_REVERSE; // R10
			// Outside xMII loopback the bit is meaningless: R13
			mdi_tx_en_reg  <= xmii_loopback ? ctl_reg.mdi_fwd : 1'b1; // R12
		end
	end

	////////////////////////////////////////////////////////////////////
	// PRBS checker: self-seeds from the stream, then free-runs
	assign chk_en   = ctl_reg.pkt_type; // R04 R05
	assign chk_pred = prbs_fb(chk_sh_reg);
	assign mismatch = rx_bit != chk_pred;
	assign err_inc  = chk_en && lock_reg && rx_valid && mismatch; // R14

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			chk_sh_reg    <= '0;
			lock_reg      <= 1'b0;
			match_cnt_reg <= 8'h00;
			miss_cnt_reg  <= 8'h00;
		end else if (!chk_en) begin
			lock_reg      <= 1'b0; // R05
			match_cnt_reg <= 8'h00;
			miss_cnt_reg  <= 8'h00;
		end else if (rx_valid && !lock_reg) begin
			// Hunting: load received bits, count agreements
			chk_sh_reg   <= {chk_sh_reg[13:0], rx_bit};
			miss_cnt_reg <= 8'h00;
			if (mismatch) begin
				match_cnt_reg <= 8'h00;
			end else if (match_cnt_reg == LOCK_LAST) begin
				lock_reg      <= 1'b1; // R07
				match_cnt_reg <= 8'h00;
			end else begin
				match_cnt_reg <= match_cnt_reg + 8'h01;
			end
		end else if (rx_valid) begin
			// Locked: local copy runs on, errors do not corrupt it
			chk_sh_reg <= {chk_sh_reg[13:0], chk_pred}; // R14
			if (!mismatch) begin
				miss_cnt_reg <= 8'h00;
			end else if (miss_cnt_reg == LOSS_LAST) begin
				lock_reg     <= 1'b0; // R07
				miss_cnt_reg <= 8'h00;
			end else begin
				miss_cnt_reg <= miss_cnt_reg + 8'h01;
			end
		end
	end

	// Sync loss latch, cleared on the edge a read samples it, so a
	// loss arriving before completion is never lost; set still wins
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			loss_reg <= 1'b0;
		end else if (chk_en && lock_reg && rx_valid && mismatch &&
			miss_cnt_reg == LOSS_LAST) begin
			loss_reg <= 1'b1; // R08
		end else if (rd_take && hit) begin
			loss_reg <= 1'b0; // R08
		end
	end

	// Error count; wrap or saturate by mode
	bist_err_counter #(
		.WIDTH (ERR_WIDTH)
	) u_err (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.inc       (err_inc), // R14
		.cont_mode (ctl_reg.err_mode), // R01 R02
		.count_reg (err_count),
		.wrap_reg  (err_wrap)
	);

	////////////////////////////////////////////////////////////////////
	// Outputs straight from flops
	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign tx_bit          = tx_bit_reg;
	assign tx_valid        = tx_valid_reg;
	assign lb_pcs          = lb_pcs_reg;
	assign lb_analog       = lb_analog_reg;
	assign lb_reverse      = lb_reverse_reg;
	assign mdi_tx_en       = mdi_tx_en_reg;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	// Last bit of a constant packet, then nothing more
	sequence s_const_last;
		ctl_reg.gen_en && !ctl_reg.pkt_type && st_reg == G_SEND &&
			bit_cnt_reg == PKT_LAST;
	endsequence
	sequence s_quiet;
		!tx_valid_reg [*2];
	endsequence

	property p_single;
		s_const_last ##1 ctl_reg.gen_en |=> s_quiet;
	endproperty
	a_single: assert property (p_single) else $error("extra packet"); // R05

	property p_repeat;
		ctl_reg.gen_en && ctl_reg.pkt_type && st_reg == G_GAP &&
			bit_cnt_reg == GAP_LAST |=> st_reg == G_SEND;
	endproperty
	a_repeat: assert property (p_repeat) else $error("no next packet"); // R03

	property p_stop;
		!ctl_reg.gen_en |=> st_reg == G_IDLE ##1 !gen_active_reg;
	endproperty
	a_stop: assert property (p_stop) else $error("generator ran on"); // R06

	property p_status;
		gen_active_reg == ($past(st_reg) == G_SEND ||
			$past(st_reg) == G_GAP);
	endproperty
	a_status: assert property (p_status) else $error("bad status"); // R09

	property p_lock_off;
		!chk_en |=> !lock_reg;
	endproperty
	a_lock_off: assert property (p_lock_off) else $error("lock held"); // R07

	property p_loss_set;
		err_inc && miss_cnt_reg == LOSS_LAST |=> loss_reg && !lock_reg;
	endproperty
	a_loss_set: assert property (p_loss_set) else $error("loss missed"); // R08

	property p_loss_hold;
		loss_reg && !(rd_take && hit) |=> loss_reg;
	endproperty
	a_loss_hold: assert property (p_loss_hold) else $error("loss fell"); // R08

	property p_lb;
		ctl_reg.lb_sel == `LB_RSVD || ctl_reg.lb_sel == `LB_NONE |=>
			!lb_pcs_reg && !lb_analog_reg && !lb_reverse_reg;
	endproperty
	a_lb: assert property (p_lb) else $error("loopback on"); // R11

	property p_analog;
		ctl_reg.lb_sel == `LB_ANALOG |=> lb_analog_reg && !lb_pcs_reg;
	endproperty
	a_analog: assert property (p_analog) else $error("analog lb"); // R10

	property p_mdi;
		xmii_loopback && !ctl_reg.mdi_fwd |=> !mdi_tx_en_reg;
	endproperty
	a_mdi: assert property (p_mdi) else $error("MDI not muted"); // R12

endmodule : prbs_bist_loopback_ctrl
`default_nettype wire

// ### sim/loop_partner.sv
`timescale 1ns/100ps
`default_nettype none
// Line partner: loops generator output back to the checker input
module loop_partner (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic tx_bit,
	input  wire logic tx_valid,
	input  wire logic flip,
	input  wire logic slow,
	output var  logic rx_bit,
	output var  logic rx_valid
);
	logic b1_reg; // First line stage bit
	logic v1_reg; // First line stage valid
	logic b2_reg; // Extra stage for slow delivery
	logic v2_reg; // Extra stage valid

	////////////////////////////////////////////////////////////////////////
	// Line delay; idle bits toggle so a stale value never looks good
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			b1_reg <= 1'b0;
			v1_reg <= 1'b0;
			b2_reg <= 1'b1;
			v2_reg <= 1'b0;
		end else begin
			// Flip corrupts each valid bit while high, on purpose
			b1_reg <= tx_valid ? (tx_bit ^ flip) : ~b1_reg;
			v1_reg <= tx_valid;
			b2_reg <= b1_reg;
			v2_reg <= v1_reg;
		end
	end

	// Slow path costs one more cycle of latency
	assign rx_bit   = slow ? b2_reg : b1_reg;
	assign rx_valid = slow ? v2_reg : v1_reg;
endmodule : loop_partner
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "bist_params.svh"
module testbench;
	import bist_pkg::*;
	localparam int PKT = 8; // Short packet for quick runs
	localparam logic [7:0] A = `STC_ADDR;
	logic        clk_sys;
	logic        reset;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        xmii_loopback;
	logic        rx_bit;
	logic        rx_valid;
	logic        tx_bit;
	logic        tx_valid;
	logic        lb_pcs;
	logic        lb_analog;
	logic        lb_reverse;
	logic        mdi_tx_en;
	logic [3:0]  err_count;
	logic        err_wrap;
	logic        flip;
	logic        slow;
	int          failures;
	int          total_checks;
	int          wraps;
	logic [3:0]  wrap_val;

	prbs_bist_loopback_ctrl #(.PKT_BITS(PKT), .GAP_BITS(2),
		.LOCK_MATCHES(16), .LOSS_MISSES(4), .ERR_WIDTH(4)) uut (
		.clk_sys, .reset, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.xmii_loopback, .rx_bit, .rx_valid, .tx_bit, .tx_valid, .lb_pcs,
		.lb_analog, .lb_reverse, .mdi_tx_en, .err_count, .err_wrap);
	loop_partner peer (.clk_sys, .reset, .tx_bit, .tx_valid, .flip,
		.slow, .rx_bit, .rx_valid);

	////////////////////////////////////////////////////////////////////////
	// Clock at 50 MHz
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Wrap pulses and the count shown with the first one
	always @(posedge clk_sys) begin
		if (err_wrap === 1'b1) begin
			if (wraps == 0) wrap_val = err_count;
			wraps++;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	// One Avalon transfer, held until waitrequest samples low
	task automatic bus(input logic wr_n, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge clk_sys);
		avs_address   <= a;
		avs_writedata <= {16'h0000, d};
		avs_read      <= !wr_n;
		avs_write     <= wr_n;
		// Only the watchdog ends a wait that never answers
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[15:0];
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] q;
		bus(1'b0, a, 16'h0000, q);
		check(q, e);
	endtask : rd

	// Poll until the lock bit shows, bounded
	task automatic wait_lock(output logic [15:0] q);
		int n;
		n = 0;
		do begin
			bus(1'b0, A, 16'h0000, q);
			n++;
		end while (q[11] !== 1'b1 && n < 60);
	endtask : wait_lock

	// Isolated single-bit errors inside packets
	task automatic hit(input int n);
		repeat (n) begin
			@(negedge clk_sys);
			while (tx_valid !== 1'b1) @(negedge clk_sys);
			@(posedge clk_sys) flip <= 1'b1;
			@(posedge clk_sys) flip <= 1'b0;
			repeat (6) @(posedge clk_sys);
		end
	endtask : hit

	// A generator stop shows on tx_valid two edges after the write
	task automatic settle;
		repeat (3) @(negedge clk_sys);
	endtask : settle

	task automatic conclude;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	// Watchdog far beyond the expected run of under a thousand cycles
	initial begin
		repeat (40000) @(posedge clk_sys);
		failures++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin : main
		logic [3:0]  codes [5];
		logic [15:0] q;
		logic [14:0] s;
		int          n;
		codes = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
		{reset, avs_read, avs_write, flip, slow, xmii_loopback} = 6'b10_0000;
		avs_address    = 8'h00;
		avs_writedata  = 32'h0000_0000;
		avs_byteenable = 4'hf;
		failures = 0;
		total_checks = 0;
		wraps = 0;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		// Reset values and unmapped address
		rd(A, 16'h0100);
		rd(8'h5c, 16'h0000);
		check({15'h0, mdi_tx_en}, 16'h0001);
		$display("test reset done");
		// Loopback codes and plain storage bits
		foreach (codes[i]) begin
			wr(A, {10'h000, codes[i], 2'b11});
			rd(A, 16'h0103 | {10'h000, codes[i], 2'b00});
			settle();
			check({13'h0, lb_reverse, lb_analog, lb_pcs}, {13'h0, codes[i][2:0]});
		end
		// Forwarding bit written only inside xMII loopback
		@(posedge clk_sys) xmii_loopback <= 1'b1;
		wr(A, 16'h0040);
		settle();
		check({15'h0, mdi_tx_en}, 16'h0001);
		wr(A, 16'h0000);
		settle();
		check({15'h0, mdi_tx_en}, 16'h0000);
		@(posedge clk_sys) xmii_loopback <= 1'b0;
		settle();
		check({15'h0, mdi_tx_en}, 16'h0001);
		$display("test loopback done");
		// PRBS packets: first packet against our own sequence
		wr(A, 16'h3000);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (tx_valid !== 1'b1 && n < 10);
		s = 15'h7fff;
		for (int i = 0; i < PKT; i++) begin
			check({15'h0, tx_bit}, {15'h0, s[14] ^ s[13]});
			s = {s[13:0], s[14] ^ s[13]};
			@(negedge clk_sys);
		end
		check({15'h0, tx_valid}, 16'h0000);
		wait_lock(q);
		check(q, 16'h3b00);
		check({12'h0, err_count}, 16'h0000);
		$display("test prbs done");
		// Single mode saturates, continuous mode wraps
		hit(40);
		check({12'h0, err_count}, 16'h000f);
		wr(A, 16'h7000);
		hit(3);
		check({15'h0, wraps != 0}, 16'h0001);
		check({12'h0, wrap_val}, 16'h0000);
		$display("test counter done");
		// Burst of errors drops lock and latches loss
		// Slow line switched in a gap, so no received bit repeats
		@(negedge clk_sys);
		while (tx_valid !== 1'b1) @(negedge clk_sys);
		while (tx_valid !== 1'b0) @(negedge clk_sys);
		repeat (2) @(posedge clk_sys);
		slow <= 1'b1;
		@(posedge clk_sys) flip <= 1'b1;
		repeat (12) @(posedge clk_sys);
		flip <= 1'b0;
		rd(A, 16'h7700);
		bus(1'b0, A, 16'h0000, q);
		check({15'h0, q[10]}, 16'h0000);
		$display("test loss done");
		// Generator off, checker keeps its lock
		wait_lock(q);
		wr(A, 16'h2000);
		settle();
		check({15'h0, tx_valid}, 16'h0000);
		rd(A, 16'h2900);
		$display("test gen off done");
		// Constant type sends exactly one packet of ones
		wr(A, 16'h0000);
		wr(A, 16'h1000);
		n = 0;
		s = 15'h0000;
		repeat (100) begin
			@(negedge clk_sys);
			if (tx_valid === 1'b1) n++;
			if (tx_valid === 1'b1 && tx_bit !== `CONST_BIT) s++;
		end
		check(n[15:0], PKT[15:0]);
		check({1'b0, s}, 16'h0000);
		bus(1'b0, A, 16'h0000, q);
		check({15'h0, q[11]}, 16'h0000);
		$display("test constant done");
		conclude();
	end : main
endmodule : testbench
`default_nettype wire
